// *** rtl/cop_top.v ***
// output stage and control pin logic of a clock generator
// assumes apb master on pclk; control pins and source clocks are asynchronous
//
// Overview of operation
// - single-ended mode drives both pins, complement in phase by default.
// - each pin's polarity is set per output from a register.
// - enable pin held high disables every output assigned to it.
// - enable pin held low enables outputs assigned to it alone; COP_MAP_GLOBAL outputs need both pins low.
// - a register bit disables any output regardless of its pin.
// - per-output skew code, 35 ps steps, 245 ps total range.
// - disable and enable wait for the running clock period to finish.
// - spread pin low turns spread off, high turns it on.
// - spread pin changes act at once, no glitch guarantee.
// - center or down spread, magnitude 0.1% to 2.5%.
// - spread reaches only outputs fed from a fractional synthesizer.
// - two independent spread profiles, usable at the same time.
// - divider select pin picks preset A when low, B when high.
// - preset divide values are whole numbers from 8 to 255.
// - output stops within 2 to 6 output clock cycles after pin release.
// - output clean within 20 us after enabling.
// - one enable pin gates true and complement pins as a pair.
// - enabling and disabling reach a known state, glitch free on pins whose polarity bit is 0.
// - enable pin may serve one output, a bank, or all outputs.
// - address-select pin sets the serial target address lsb.
// - source pins choose crystal or one of two clock inputs.
// - a control bit picks source from pins or from a register.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "cop_consts.vh"

module cop_top #(
  parameter NOUT = 4,
  parameter NINT = 2
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [NOUT-1:0] source_clock,
  input wire [1:0] output_enable_low_pin,
  input wire spread_enable_pin_synth0,
  input wire spread_enable_pin_synth1,
  input wire [NINT-1:0] int_divider_select_pin,
  input wire [1:0] input_source_select_pins,
  input wire address_select_pin,
  output reg [NOUT-1:0] true_output_pin,
  output reg [NOUT-1:0] complement_output_pin,
  output reg [NOUT-1:0] output_spread_active,
  output reg [3*NOUT-1:0] skew_code,
  output reg [1:0] spread_on,
  output reg [1:0] spread_down,
  output reg [9:0] spread_magnitude,
  output reg [8*NINT-1:0] integer_divider_value,
  output reg [1:0] active_input_source,
  output reg [6:0] serial_target_address
);

  // ----------------------------------------------------
  // register storage
  // ----------------------------------------------------
  reg [2:0] ctrl_q;
  reg [NOUT-1:0] dis_q;
  reg [15:0] pol_q;
  reg [15:0] oemap_q;
  reg [23:0] skew_q;
  reg [15:0] spread_q;
  reg [15:0] src_q;
  reg [8*NINT-1:0] diva_q;
  reg [8*NINT-1:0] divb_q;
  reg [6:0] addr_q;
  // enable state per output; also read back through the status word
  reg [NOUT-1:0] en_q;

  // ----------------------------------------------------
  // control pin synchronisers
  // ----------------------------------------------------
  reg [7:0] pin_s1_q;
  reg [7:0] pin_s2_q;
  reg [NINT-1:0] fs_s1_q;
  reg [NINT-1:0] fs_s2_q;
  wire [7:0] pin_raw;

  assign pin_raw = {address_select_pin, input_source_select_pins,
                    spread_enable_pin_synth1, spread_enable_pin_synth0,
                    output_enable_low_pin, 1'b0};

  // two stages before any use of a pin level
  // the first stage may go metastable, so only the second stage is read
  // divider select pins get their own pair of stages
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      fs_s1_q <= {NINT{1'b0}};
      fs_s2_q <= {NINT{1'b0}};
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      fs_s1_q <= int_divider_select_pin;
      fs_s2_q <= fs_s1_q;
    end
  end

  // ----------------------------------------------------
  // synchronised pin levels
  // ----------------------------------------------------
  // enable pins are active low; oe0_low and oe1_low are high when enabled
  wire oe0_low;
  wire oe1_low;
  wire [1:0] sspin;
  wire [1:0] srcpin;
  wire addrpin;
  assign oe0_low = ~pin_s2_q[1];
  assign oe1_low = ~pin_s2_q[2];
  assign sspin = pin_s2_q[4:3];
  assign srcpin = pin_s2_q[6:5];
  assign addrpin = pin_s2_q[7];

  // ----------------------------------------------------
  // apb slave
  // ----------------------------------------------------
  wire acc;
  wire wr;
  reg [31:0] rd_d;
  reg err_d;
  // a write lands only at the edge where pready is seen high
  assign acc = psel & penable;
  assign wr = acc & pready & pwrite;

  // ----------------------------------------------------
  // value limits
  // ----------------------------------------------------
  // codes below the minimum are raised, so a divider never sees an illegal ratio
  // clamp a preset divide value into its legal range
  function [7:0] div_clamp;
    input [7:0] v;
    begin
      div_clamp = (v < `COP_DIV_MIN) ? `COP_DIV_MIN : v;
    end
  endfunction

  // clamp a spread magnitude code (units of 0.1 percent)
  function [4:0] mag_clamp;
    input [4:0] v;
    begin
      if (v < `COP_MAG_MIN)
        mag_clamp = `COP_MAG_MIN;
      else if (v > `COP_MAG_MAX)
        mag_clamp = `COP_MAG_MAX;
      else
        mag_clamp = v;
    end
  endfunction

  // read mux and unmapped address detection
  always @* begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    case (paddr)
      `COP_OFF_CTRL: rd_d[2:0] = ctrl_q;
      `COP_OFF_DIS: rd_d[NOUT-1:0] = dis_q;
      `COP_OFF_POL: rd_d[15:0] = pol_q;
      `COP_OFF_OEMAP: rd_d[15:0] = oemap_q;
      `COP_OFF_SKEW: rd_d[23:0] = skew_q;
      `COP_OFF_SPREAD: rd_d[15:0] = spread_q;
      `COP_OFF_SRC: rd_d[15:0] = src_q;
      `COP_OFF_DIVA: rd_d[8*NINT-1:0] = diva_q;
      `COP_OFF_DIVB: rd_d[8*NINT-1:0] = divb_q;
      // status word: live pin levels, chosen source and enable state
      `COP_OFF_STAT: rd_d[NOUT+9:0] = {sspin, fs_s2_q[0], oe1_low, oe0_low,
                                        addrpin, srcpin, active_input_source,
                                        en_q};
      `COP_OFF_ADDR: rd_d[6:0] = serial_target_address;
      default: err_d = 1'b1;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  // read data and error stand only while pready is high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc & ~pready;
      prdata <= (acc & ~pready & ~pwrite) ? rd_d : 32'h00000000;
      pslverr <= acc & ~pready & err_d;
    end
  end

  // ----------------------------------------------------
  // register writes
  // ----------------------------------------------------
  integer k;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `COP_RST_CTRL;
      dis_q <= {NOUT{1'b0}};
      pol_q <= `COP_RST_POL;
      oemap_q <= `COP_RST_OEMAP;
      skew_q <= `COP_RST_SKEW;
      spread_q <= `COP_RST_SPREAD;
      src_q <= `COP_RST_SRC;
      diva_q <= {NINT{`COP_RST_DIV}};
      divb_q <= {NINT{`COP_RST_DIV}};
      addr_q <= `COP_RST_ADDR;
    end else if (wr) begin
      case (paddr)
        `COP_OFF_CTRL: ctrl_q <= pwdata[2:0];
        `COP_OFF_DIS: dis_q <= pwdata[NOUT-1:0];
        `COP_OFF_POL: pol_q <= pwdata[15:0];
        `COP_OFF_OEMAP: oemap_q <= pwdata[15:0];
        `COP_OFF_SKEW: skew_q <= pwdata[23:0];
        `COP_OFF_SPREAD: begin
          spread_q <= pwdata[15:0];
          spread_q[4:0] <= mag_clamp(pwdata[4:0]);
          spread_q[12:8] <= mag_clamp(pwdata[12:8]);
        end
        `COP_OFF_SRC: src_q <= pwdata[15:0];
        `COP_OFF_DIVA: begin
          for (k = 0; k < NINT; k = k + 1)
            diva_q[8*k +: 8] <= div_clamp(pwdata[8*k +: 8]);
        end
        `COP_OFF_DIVB: begin
          for (k = 0; k < NINT; k = k + 1)
            divb_q[8*k +: 8] <= div_clamp(pwdata[8*k +: 8]);
        end
        `COP_OFF_ADDR: addr_q <= pwdata[6:0];
        // unmapped and read-only offsets change nothing
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // ----------------------------------------------------
  // spread, source, divider and address outputs
  // ----------------------------------------------------
  // spread byte per synth: [4:0] magnitude, [5] down, [6] reg enable, [7] use pin
  wire [1:0] spread_d;
  assign spread_d[0] = spread_q[7] ? sspin[0] : spread_q[6];
  assign spread_d[1] = spread_q[15] ? sspin[1] : spread_q[14];
  // pin-driven spread changes act at once; the synthesizer may glitch
  // own loop variable, so each process is the only writer of it
  integer j;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spread_on <= 2'h0;
      spread_down <= 2'h0;
      spread_magnitude <= 10'h000;
      active_input_source <= 2'h0;
      serial_target_address <= `COP_RST_ADDR;
      integer_divider_value <= {NINT{`COP_RST_DIV}};
    end else begin
      spread_on <= spread_d;
      spread_down <= {spread_q[13], spread_q[5]};
      spread_magnitude <= {spread_q[12:8], spread_q[4:0]};
      // input switching is not glitch free; the controller should settle the pins early
      active_input_source <= ctrl_q[0] ? ctrl_q[2:1] : srcpin;
      // the pin sets only the lowest address bit; upper bits come from the register
      serial_target_address <= {addr_q[6:1], addrpin};
      for (j = 0; j < NINT; j = j + 1)
        integer_divider_value[8*j +: 8] <= fs_s2_q[j] ?
          divb_q[8*j +: 8] : diva_q[8*j +: 8];
    end
  end

  // ----------------------------------------------------
  // per-output enable, gating and polarity
  // ----------------------------------------------------
  // three stages per source clock: two to synchronise, one to find its falling edge
  reg [NOUT-1:0] clk_s1_q;
  reg [NOUT-1:0] clk_s2_q;
  reg [NOUT-1:0] clk_s3_q;
  wire [NOUT-1:0] want_en;
  wire [NOUT-1:0] period_end;

  // one copy of the enable and gating logic per output
  genvar g;
  generate
    for (g = 0; g < NOUT; g = g + 1) begin : g_out
      wire [1:0] map;
      reg pin_en;
      assign map = oemap_q[2*g +: 2];

      // pin enable from the assigned output enable pin
      always @* begin
        case (map)
          `COP_MAP_NONE: pin_en = 1'b1;
          `COP_MAP_PIN0: pin_en = oe0_low;
          `COP_MAP_PIN1: pin_en = oe1_low;
          `COP_MAP_GLOBAL: pin_en = oe0_low & oe1_low;
          default: pin_en = 1'b0;
        endcase
      end

      // register disable overrides an enabling pin
      assign want_en[g] = pin_en & ~dis_q[g];
      // falling edge of the source marks a finished period
      // a stopped source never ends a period, so its enable state freezes
      assign period_end[g] = clk_s3_q[g] & ~clk_s2_q[g];

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          clk_s1_q[g] <= 1'b0;
          clk_s2_q[g] <= 1'b0;
          clk_s3_q[g] <= 1'b0;
          en_q[g] <= 1'b0;
          true_output_pin[g] <= 1'b0;
          complement_output_pin[g] <= 1'b0;
          output_spread_active[g] <= 1'b0;
          skew_code[3*g +: 3] <= 3'h0;
        end else begin
          clk_s1_q[g] <= source_clock[g];
          clk_s2_q[g] <= clk_s1_q[g];
          clk_s3_q[g] <= clk_s2_q[g];
          // change state only while the clock sits low
          if (period_end[g])
            en_q[g] <= want_en[g];
          // both pins gated together, driven low when off
          // a disabled pair rests low, so the next enable starts from a known level
          true_output_pin[g] <= en_q[g] & (clk_s2_q[g] ^ pol_q[2*g]);
          complement_output_pin[g] <= en_q[g] & (clk_s2_q[g] ^ pol_q[2*g+1]);
          // spread reaches an output only when a fractional synthesizer feeds it
          output_spread_active[g] <= (src_q[2*g +: 2] == `COP_SRC_SYNTH0 & spread_on[0]) |
                                     (src_q[2*g +: 2] == `COP_SRC_SYNTH1 & spread_on[1]);
          skew_code[3*g +: 3] <= skew_q[3*g +: 3];
        end
      end
    end
  endgenerate

endmodule // cop_top

`default_nettype wire

// *** rtl/cop_consts.vh ***
// constants for the clock output pin control block
// assumes byte addressing over a 32-bit apb register bus
`ifndef COP_CONSTS_VH
`define COP_CONSTS_VH
// ----------------------------------------------------
// register byte offsets
// ----------------------------------------------------
`define COP_OFF_CTRL 8'h00
`define COP_OFF_DIS 8'h04
`define COP_OFF_POL 8'h08
`define COP_OFF_OEMAP 8'h0C
`define COP_OFF_SKEW 8'h10
`define COP_OFF_SPREAD 8'h14
`define COP_OFF_SRC 8'h18
`define COP_OFF_DIVA 8'h1C
`define COP_OFF_DIVB 8'h20
`define COP_OFF_STAT 8'h24
`define COP_OFF_ADDR 8'h28
// ----------------------------------------------------
// reset values
// ----------------------------------------------------
`define COP_RST_CTRL 3'h0
`define COP_RST_POL 16'h0000
`define COP_RST_OEMAP 16'h0000
`define COP_RST_SKEW 24'h000000
`define COP_RST_SPREAD 16'h0000
`define COP_RST_SRC 16'h0000
`define COP_RST_DIV 8'h08
`define COP_RST_ADDR 7'h35
// ----------------------------------------------------
// limits and codes
// ----------------------------------------------------
`define COP_DIV_MIN 8'h08
`define COP_MAG_MIN 5'h01
`define COP_MAG_MAX 5'h19
`define COP_SKEW_STEP_PS 35
`define COP_SKEW_RANGE_PS 245
`define COP_MAP_NONE 2'h0
`define COP_MAP_PIN0 2'h1
`define COP_MAP_PIN1 2'h2
`define COP_MAP_GLOBAL 2'h3
`define COP_SRC_SYNTH0 2'h0
`define COP_SRC_SYNTH1 2'h1
`endif

// *** bench/cop_ctl_model.sv ***
// system controller model driving the control pins
// assumes the bench asks for pin changes; source clocks run free
`timescale 1ns/1ns
`default_nettype none
module cop_ctl_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [8:0] pins_in,
  output logic [3:0] source_clock,
  output logic [8:0] pins_q
);
  logic sclk_q = 1'b0;
  // source clock unrelated to pclk; its edges never meet a pclk rising edge
  always #12 sclk_q = ~sclk_q;
  assign source_clock = {sclk_q, ~sclk_q, sclk_q, ~sclk_q};
  // pins move just after a pclk edge, then hold
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q <= 9'h003;
    end else if (load) begin
      pins_q <= pins_in;
    end
  end
endmodule // cop_ctl_model
`default_nettype wire

// *** bench/cop_top_sva.sv ***
// checker on the ports of the clock output pin block
// assumes aligned apb writes; tracks written registers itself
`timescale 1ns/1ns
`default_nettype none
module cop_top_chk #(parameter NOUT = 4, parameter NINT = 2) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [1:0] output_enable_low_pin,
  input wire logic spread_enable_pin_synth0,
  input wire logic [1:0] input_source_select_pins,
  input wire logic address_select_pin,
  input wire logic [NOUT-1:0] true_output_pin,
  input wire logic [NOUT-1:0] complement_output_pin,
  input wire logic [1:0] spread_on,
  input wire logic [9:0] spread_magnitude,
  input wire logic [8*NINT-1:0] integer_divider_value,
  input wire logic [1:0] active_input_source,
  input wire logic [6:0] serial_target_address
);
  logic [31:0] rg_q [0:10];
  logic [4:0] off_q;
  logic [4:0] on_q;
  integer i;
  // output 0 should be off or running, counted in cycles
  wire off_w = (&output_enable_low_pin && rg_q[3][1:0] != 2'h0) || rg_q[1][0];
  wire on_w = ~|output_enable_low_pin && !rg_q[1][0];
  // shadow of every completed register write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 11; i = i + 1)
        rg_q[i] <= 32'h0;
      off_q <= 5'h00;
      on_q <= 5'h00;
    end else begin
      if (psel && penable && pready && pwrite && paddr < 8'h2C)
        rg_q[paddr[5:2]] <= pwdata;
      off_q <= off_w ? off_q + {4'h0, off_q != 5'h14} : 5'h00;
      on_q <= on_w ? on_q + {4'h0, on_q != 5'h14} : 5'h00;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pair_in_phase: assert property ((rg_q[2][1:0] == 2'h0)[*3] |->
    true_output_pin[0] == complement_output_pin[0]) else $error("pair out of phase");
  a_pair_inverted: assert property ((rg_q[2][1:0] == 2'h2)[*3] |->
    !(true_output_pin[0] && complement_output_pin[0])) else $error("polarity ignored");
  a_off_stays_low: assert property (off_q == 5'h14 |->
    true_output_pin[0] == 1'b0 && complement_output_pin[0] == 1'b0) else $error("disabled output runs");
  a_on_toggles: assert property (on_q == 5'h14 |->
    ##[1:12] true_output_pin[0] != $past(true_output_pin[0])) else $error("enabled output stuck");
  a_spread_pin: assert property ((rg_q[5][7] && $stable(spread_enable_pin_synth0))[*5] |->
    spread_on[0] == spread_enable_pin_synth0) else $error("spread pin ignored");
  a_mag_bounded: assert property (spread_magnitude[4:0] <= 5'h19 &&
    spread_magnitude[9:5] <= 5'h19) else $error("magnitude above limit");
  a_div_min: assert property (integer_divider_value[7:0] >= 8'h08 &&
    integer_divider_value[8*NINT-1 -: 8] >= 8'h08) else $error("divide value below 8");
  a_addr_lsb: assert property ($stable(address_select_pin)[*4] |->
    serial_target_address[0] == address_select_pin) else $error("address lsb wrong");
  a_sync_delay: assert property ($stable(address_select_pin)[*4] ##1 $changed(address_select_pin) |=>
    $stable(serial_target_address)[*2]) else $error("pin acted unsynchronised");
  a_src_pins: assert property ((!rg_q[0][0] && $stable(input_source_select_pins))[*4] |->
    active_input_source == input_source_select_pins) else $error("source pins ignored");
  c_off: cover property (off_q == 5'h14);
  c_on: cover property (on_q == 5'h14);
  c_spread: cover property ($rose(spread_on[0]));
endmodule // cop_top_chk
bind cop_top cop_top_chk #(.NOUT(NOUT), .NINT(NINT)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .paddr(paddr), .pwdata(pwdata), .output_enable_low_pin(output_enable_low_pin),
  .spread_enable_pin_synth0(spread_enable_pin_synth0), .input_source_select_pins(input_source_select_pins),
  .address_select_pin(address_select_pin), .true_output_pin(true_output_pin),
  .complement_output_pin(complement_output_pin), .spread_on(spread_on), .spread_magnitude(spread_magnitude),
  .integer_divider_value(integer_divider_value), .active_input_source(active_input_source),
  .serial_target_address(serial_target_address));
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the clock output pin block
// assumes cop_top with default parameters and the pin model
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t mismatch got %h want %h", $time, g, e); end end
module tb_top;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, load, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [8:0] pins_in, pv;
  logic [3:0] sclk, tp, cp;
  logic [1:0] son, sdn, src;
  logic [9:0] mag;
  logic [11:0] skew;
  logic [15:0] divv;
  logic [6:0] taddr;
  logic [3:0] osa;
  logic [32:0] exp_v;
  logic [32:0] exp_q[$];
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 32'hABCA;
  int i;
  always #5 pclk = ~pclk;
  cop_ctl_model u_ctl (.pclk(pclk), .presetn(presetn), .load(load), .pins_in(pins_in),
    .source_clock(sclk), .pins_q(pv));
  cop_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .source_clock(sclk), .output_enable_low_pin(pv[1:0]), .spread_enable_pin_synth0(pv[2]),
    .spread_enable_pin_synth1(pv[3]), .int_divider_select_pin(pv[5:4]), .input_source_select_pins(pv[7:6]),
    .address_select_pin(pv[8]), .true_output_pin(tp), .complement_output_pin(cp), .output_spread_active(osa),
    .skew_code(skew), .spread_on(son), .spread_down(sdn), .spread_magnitude(mag),
    .integer_divider_value(divv), .active_input_source(src), .serial_target_address(taddr));
  task tally_and_finish;
    begin
      if (failures == 0 && num_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // one apb transfer; the expected {pslverr, prdata} is queued
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    begin
      @(posedge pclk);
      exp_q.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic pins(input logic [8:0] v);
    begin
      @(posedge pclk);
      load <= 1'b1;
      pins_in <= v;
      @(posedge pclk);
      load <= 1'b0;
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge pclk);
  endtask
  // let enables settle, then see which pins ever went high
  task automatic watch(input logic [3:0] en);
    logic [3:0] st, sc;
    begin
      st = 4'h0;
      sc = 4'h0;
      wt(20);
      repeat (20) begin
        @(negedge pclk);
        st = st | tp;
        sc = sc | cp;
      end
      `CHK({st, sc}, {en, en})
    end
  endtask
  // compare each answer with the oldest queued note
  always @(posedge pclk) begin
    cyc++;
    if (presetn && pready === 1'b1) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1FFFFFFFF;
      `CHK({pslverr, prdata}, exp_v)
    end
    if (cyc == 20000) begin
      failures++;
      tally_and_finish;
    end
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, load, paddr, pwdata} = 0;
    pins_in = 9'h003;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h08, 32'h0, 33'h0);
    apb(1'b0, 8'h28, 32'h0, 33'h34);
    apb(1'b1, 8'h2C, 32'h1, 33'h100000000);
    apb(1'b0, 8'h2C, 32'h0, 33'h100000000);
    apb(1'b1, 8'h1C, 32'h0203, 33'h0);
    apb(1'b1, 8'h20, 32'hFF40, 33'h0);
    apb(1'b0, 8'h1C, 32'h0, 33'h0808);
    apb(1'b1, 8'h10, 32'hFAC, 33'h0);
    wt(2);
    `CHK(skew, 12'hFAC)
    pins(9'h013);
    wt(6);
    `CHK(divv, 16'h0840)
    apb(1'b1, 8'h0C, 32'h27, 33'h0);
    for (i = 0; i < 4; i++) begin
      pins({7'h00, i[1:0]});
      watch({1'b1, ~i[1], ~i[0], i == 0});
    end
    pins(9'h000);
    apb(1'b1, 8'h04, 32'h1, 33'h0);
    watch(4'hE);
    apb(1'b1, 8'h04, 32'h0, 33'h0);
    apb(1'b1, 8'h08, 32'h2, 33'h0);
    watch(4'hF);
    apb(1'b1, 8'h14, 32'h7FA5, 33'h0);
    apb(1'b1, 8'h18, 32'h24, 33'h0);
    for (i = 0; i < 2; i++) begin
      pins({6'h00, i[0], 2'h0});
      wt(6);
      `CHK({son, sdn, mag}, {1'b1, i[0], 2'h3, 5'h19, 5'h05})
      `CHK(osa, {i[0], 1'b0, 1'b1, i[0]})
    end
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      pins({r[2:0], 6'h04});
      wt(6);
      `CHK({taddr, src}, {6'h1A, r[2:0]})
    end
    apb(1'b1, 8'h00, 32'h5, 33'h0);
    wt(4);
    `CHK(src, 2'h2)
    apb(1'b1, 8'h28, 32'h4B, 33'h0);
    apb(1'b0, 8'h28, 32'h0, {26'h0, 6'h25, r[2]});
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
